// >>> verilog/volume_regs_pkg.sv
`default_nettype none

package volume_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SILENCE_CFG   = 8'h03;
    localparam logic [7:0] OFF_LEFT_GAIN     = 8'h04;
    localparam logic [7:0] OFF_RIGHT_GAIN    = 8'h05;
    localparam logic [7:0] OFF_OUTPUT_STAGE  = 8'h06;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SILENCE_CFG   = 8'h80;
    localparam logic [7:0] WMASK_SILENCE_CFG = 8'h83;
    localparam logic [7:0] RST_GAIN_CODE     = 8'hCF;
    localparam logic [7:0] RST_OUTPUT_STAGE  = 8'h51;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FADE_BIT         = 7;
    localparam int RIGHT_SILENCE    = 1;
    localparam int LEFT_SILENCE     = 0;
    localparam int BRIDGE_BIT       = 7;
    localparam int RATE_MSB         = 6;
    localparam int RATE_LSB         = 4;
    localparam int AGAIN_MSB        = 3;
    localparam int AGAIN_LSB        = 2;
    localparam int MONO_SRC_BIT     = 1;

    // ------------------------------------------------------------
    // Gain mapping and switching rate table
    // ------------------------------------------------------------
    localparam logic [7:0] MUTE_THRESHOLD  = 8'h07;
    localparam logic [8:0] GAIN_ZERO_CODE  = 9'h0CF;
    localparam logic [39:0] PWM_MULT_TABLE =
        {5'h18, 5'h14, 5'h10, 5'h0E, 5'h0C, 5'h0A, 5'h08, 5'h06};
    localparam logic [5:0] PWM_FIELD_W     = 6'h05;

    // ------------------------------------------------------------
    // Control port
    // ------------------------------------------------------------
    // Arbitrary base address; its low bit comes from the strap pin
    localparam logic [6:0] PORT_ADDR_BASE  = 7'h50;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0] ACK_DONE        = 4'h9;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SUB,
        ST_WDATA,
        ST_RDATA
    } port_state_e;

endpackage

`default_nettype wire

// >>> verilog/control_port_slave.sv
`timescale 1ns/1ps
`default_nettype none

module control_port_slave (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Two-wire pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Register side
    input  wire logic [6:0] dev_addr,
    input  wire logic [7:0] rd_data,
    output logic      [7:0] reg_ptr,
    output logic      [7:0] wr_addr,
    output logic      [7:0] wr_data,
    output logic            wr_en
);

    // ------------------------------------------------------------
    // Pin filtering
    // ------------------------------------------------------------
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic       scl_f_reg;
    logic       sda_f_reg;

    wire scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    wire sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    wire scl_rise   = scl_f_next & ~scl_f_reg;
    wire scl_fall   = ~scl_f_next & scl_f_reg;
    wire start_seen = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
    wire stop_seen  = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_f_reg    <= 1'b1;
            sda_f_reg    <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            scl_f_reg    <= scl_f_next;
            sda_f_reg    <= sda_f_next;
        end
    end

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    volume_regs_pkg::port_state_e state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic       rw_reg;
    logic       nack_reg;

    wire in_byte   = (state_reg != volume_regs_pkg::ST_IDLE);
    wire byte_done = (cnt_reg == volume_regs_pkg::BITS_PER_BYTE);
    wire ack_done  = (cnt_reg == volume_regs_pkg::ACK_DONE);
    wire to_read   = (state_reg == volume_regs_pkg::ST_RDATA) ||
                     ((state_reg == volume_regs_pkg::ST_ADDR) && rw_reg);

    assign reg_ptr = ptr_reg;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= volume_regs_pkg::ST_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg   <= 8'h00;
            rw_reg    <= 1'b0;
            nack_reg  <= 1'b0;
            wr_en     <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 8'h00;
            sda_oe_n  <= 1'b1;
            sda_out   <= 1'b0;
        end
        else
        begin
            wr_en   <= 1'b0;
            sda_out <= 1'b0;
            if (start_seen)
            begin
                state_reg <= volume_regs_pkg::ST_ADDR;
                cnt_reg   <= 4'h0;
                sda_oe_n  <= 1'b1;
            end
            else if (stop_seen)
            begin
                state_reg <= volume_regs_pkg::ST_IDLE;
                sda_oe_n  <= 1'b1;
            end
            else if (in_byte && scl_rise)
            begin
                if (cnt_reg < volume_regs_pkg::BITS_PER_BYTE)
                begin
                    if (state_reg != volume_regs_pkg::ST_RDATA)
                        shift_reg <= {shift_reg[6:0], sda_f_next};
                    cnt_reg <= cnt_reg + 4'h1;
                end
                else if (byte_done)
                begin
                    nack_reg <= sda_f_next;
                    cnt_reg  <= volume_regs_pkg::ACK_DONE;
                end
            end
            else if (in_byte && scl_fall)
            begin
                if (byte_done)
                begin
                    unique case (state_reg)
                        volume_regs_pkg::ST_ADDR:
                        begin
                            if (shift_reg[7:1] == dev_addr)
                            begin
                                sda_oe_n <= 1'b0;
                                rw_reg   <= shift_reg[0];
                            end
                            else
                                state_reg <= volume_regs_pkg::ST_IDLE;
                        end
                        volume_regs_pkg::ST_SUB:
                        begin
                            ptr_reg  <= shift_reg;
                            sda_oe_n <= 1'b0;
                        end
                        volume_regs_pkg::ST_WDATA:
                        begin
                            wr_en    <= 1'b1;
                            wr_addr  <= ptr_reg;
                            wr_data  <= shift_reg;
                            ptr_reg  <= ptr_reg + 8'h01;
                            sda_oe_n <= 1'b0;
                        end
                        default:
                            sda_oe_n <= 1'b1;
                    endcase
                end
                else if (ack_done)
                begin
                    cnt_reg <= 4'h0;
                    if ((state_reg == volume_regs_pkg::ST_RDATA) && nack_reg)
                    begin
                        state_reg <= volume_regs_pkg::ST_IDLE;
                        sda_oe_n  <= 1'b1;
                    end
                    else if (to_read)
                    begin
                        state_reg <= volume_regs_pkg::ST_RDATA;
                        shift_reg <= rd_data;
                        sda_oe_n  <= rd_data[7];
                        ptr_reg   <= ptr_reg + 8'h01;
                    end
                    else
                    begin
                        sda_oe_n  <= 1'b1;
                        state_reg <= (state_reg == volume_regs_pkg::ST_ADDR) ?
                                     volume_regs_pkg::ST_SUB : volume_regs_pkg::ST_WDATA;
                    end
                end
                else if ((state_reg == volume_regs_pkg::ST_RDATA) && (cnt_reg != 4'h0))
                begin
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    sda_oe_n  <= shift_reg[6];
                end
            end
        end
    end

endmodule // control_port_slave

`default_nettype wire

// >>> verilog/channel_volume_mute_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Fade bit 7 enables fading, resets set
// - Config bits 6:2 read zero, not writable
// - Right silence bit mutes right channel
// - Left silence bit mutes left; clear unmutes at codes seven and up
// - Left code: all ones +24 dB, 7 -100 dB
// - Codes below seven force the channel mute
// - Right code uses same gain mapping
// - Both gain codes reset to unity 0xCF
// - Bit 7 picks stereo or parallel bridge
// - Bits 6:4 pick switching multiple, halved at double speed
// - Bit 1 picks mono source channel
module channel_volume_mute_regs (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Control port pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       addr_sel,
    // Serial port speed from digital control
    input  wire logic       double_speed,
    // Channel controls
    output logic            fade_enable,
    output logic            left_mute,
    output logic            right_mute,
    output logic      [8:0] left_gain_half_db,
    output logic      [8:0] right_gain_half_db,
    // Output stage controls
    output logic            parallel_bridge_select,
    output logic      [4:0] pwm_rate_multiple,
    output logic      [1:0] analog_gain_select,
    output logic            mono_source_select
);

    // ------------------------------------------------------------
    // Address strap and control port
    // ------------------------------------------------------------
    logic [2:0] strap_sync_reg;
    logic       strap_reg;
    logic [7:0] reg_ptr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic [7:0] rd_data;

    wire [6:0] dev_addr = {volume_regs_pkg::PORT_ADDR_BASE[6:1], strap_reg};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            strap_sync_reg <= 3'h0;
            strap_reg      <= 1'b0;
        end
        else
        begin
            strap_sync_reg <= {strap_sync_reg[1:0], addr_sel};
            if (strap_sync_reg[1] == strap_sync_reg[2])
                strap_reg <= strap_sync_reg[2];
        end
    end

    control_port_slave port_i (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe_n (sda_oe_n),
        .dev_addr (dev_addr),
        .rd_data  (rd_data),
        .reg_ptr  (reg_ptr),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .wr_en    (wr_en)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] fade_and_channel_silence_reg;
    logic [7:0] left_gain_code_reg;
    logic [7:0] right_gain_code_reg;
    logic [7:0] output_stage_config_reg;

    wire wr_silence = wr_en && (wr_addr == volume_regs_pkg::OFF_SILENCE_CFG);
    wire wr_left    = wr_en && (wr_addr == volume_regs_pkg::OFF_LEFT_GAIN);
    wire wr_right   = wr_en && (wr_addr == volume_regs_pkg::OFF_RIGHT_GAIN);
    wire wr_stage   = wr_en && (wr_addr == volume_regs_pkg::OFF_OUTPUT_STAGE);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fade_and_channel_silence_reg <= volume_regs_pkg::RST_SILENCE_CFG;
            left_gain_code_reg           <= volume_regs_pkg::RST_GAIN_CODE;
            right_gain_code_reg          <= volume_regs_pkg::RST_GAIN_CODE;
            output_stage_config_reg      <= volume_regs_pkg::RST_OUTPUT_STAGE;
        end
        else
        begin
            if (wr_silence)
                fade_and_channel_silence_reg <=
                    wr_data & volume_regs_pkg::WMASK_SILENCE_CFG;
            if (wr_left)
                left_gain_code_reg <= wr_data;
            if (wr_right)
                right_gain_code_reg <= wr_data;
            if (wr_stage)
                output_stage_config_reg <= wr_data;
        end
    end

    assign rd_data =
        (reg_ptr == volume_regs_pkg::OFF_SILENCE_CFG)  ? fade_and_channel_silence_reg :
        (reg_ptr == volume_regs_pkg::OFF_LEFT_GAIN)    ? left_gain_code_reg :
        (reg_ptr == volume_regs_pkg::OFF_RIGHT_GAIN)   ? right_gain_code_reg :
        (reg_ptr == volume_regs_pkg::OFF_OUTPUT_STAGE) ? output_stage_config_reg :
                                                         volume_regs_pkg::READ_UNMAPPED;

    // ------------------------------------------------------------
    // Channel and output stage decode
    // ------------------------------------------------------------
    logic       left_mute_reg;
    logic       right_mute_reg;
    logic [8:0] left_gain_reg;
    logic [8:0] right_gain_reg;
    logic [4:0] pwm_mult_reg;

    wire       left_low  = left_gain_code_reg < volume_regs_pkg::MUTE_THRESHOLD;
    wire       right_low = right_gain_code_reg < volume_regs_pkg::MUTE_THRESHOLD;
    wire       left_mute_next  =
        fade_and_channel_silence_reg[volume_regs_pkg::LEFT_SILENCE] | left_low;
    wire       right_mute_next =
        fade_and_channel_silence_reg[volume_regs_pkg::RIGHT_SILENCE] | right_low;
    // Signed half-decibel gain relative to unity
    wire [8:0] left_gain_next  =
        {1'b0, left_gain_code_reg} - volume_regs_pkg::GAIN_ZERO_CODE;
    wire [8:0] right_gain_next =
        {1'b0, right_gain_code_reg} - volume_regs_pkg::GAIN_ZERO_CODE;
    wire [2:0] rate_code =
        output_stage_config_reg[volume_regs_pkg::RATE_MSB:volume_regs_pkg::RATE_LSB];
    wire [5:0] rate_idx  = 6'(rate_code) * volume_regs_pkg::PWM_FIELD_W;
    wire [4:0] rate_full = volume_regs_pkg::PWM_MULT_TABLE[rate_idx +: 5];
    wire [4:0] pwm_mult_next = double_speed ? {1'b0, rate_full[4:1]} : rate_full;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            left_mute_reg  <= 1'b0;
            right_mute_reg <= 1'b0;
            left_gain_reg  <= 9'h000;
            right_gain_reg <= 9'h000;
            pwm_mult_reg   <= 5'h10;
        end
        else
        begin
            left_mute_reg  <= left_mute_next;
            right_mute_reg <= right_mute_next;
            left_gain_reg  <= left_gain_next;
            right_gain_reg <= right_gain_next;
            pwm_mult_reg   <= pwm_mult_next;
        end
    end

    assign fade_enable            =
        fade_and_channel_silence_reg[volume_regs_pkg::FADE_BIT];
    assign left_mute              = left_mute_reg;
    assign right_mute             = right_mute_reg;
    assign left_gain_half_db      = left_gain_reg;
    assign right_gain_half_db     = right_gain_reg;
    assign parallel_bridge_select = output_stage_config_reg[volume_regs_pkg::BRIDGE_BIT];
    assign pwm_rate_multiple      = pwm_mult_reg;
    assign analog_gain_select     =
        output_stage_config_reg[volume_regs_pkg::AGAIN_MSB:volume_regs_pkg::AGAIN_LSB];
    assign mono_source_select     =
        output_stage_config_reg[volume_regs_pkg::MONO_SRC_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    fade_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_silence |=> fade_enable == $past(wr_data[7]))
        else $error("fade enable did not follow write");

    reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_ptr == volume_regs_pkg::OFF_SILENCE_CFG) |-> (rd_data[6:2] == 5'h00))
        else $error("reserved config bits read nonzero");

    right_mute_a: assert property (@(posedge sys_clk) disable iff (rst)
        fade_and_channel_silence_reg[1] |=> right_mute)
        else $error("right silence bit did not mute");

    left_unmute_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!fade_and_channel_silence_reg[0] && !left_low) |=> !left_mute)
        else $error("left channel stayed muted");

    left_top_a: assert property (@(posedge sys_clk) disable iff (rst)
        (left_gain_code_reg == 8'hFE) |=> (left_gain_half_db == 9'h02F))
        else $error("left code FE not plus 23.5 dB");

    low_code_mute_a: assert property (@(posedge sys_clk) disable iff (rst)
        (left_low || right_low) |=>
            (left_mute || !$past(left_low)) && (right_mute || !$past(right_low)))
        else $error("low code did not mute");

    right_floor_a: assert property (@(posedge sys_clk) disable iff (rst)
        (right_gain_code_reg == 8'h07) |-> !right_low ##1 (right_gain_half_db == 9'h138))
        else $error("right code 07 not minus 100 dB");

    gain_reset_a: assert property (@(posedge sys_clk)
        $past(rst) |-> (left_gain_code_reg == 8'hCF) && (right_gain_code_reg == 8'hCF))
        else $error("gain codes not at unity after reset");

    gain_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        (($past(left_gain_code_reg) != 8'h00) &&
         (left_gain_code_reg == $past(left_gain_code_reg) - 8'h01)) |=>
            (left_gain_half_db == $past(left_gain_half_db) - 9'h001))
        else $error("gain step not half a decibel per code");

    bridge_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_stage |=> parallel_bridge_select == $past(wr_data[7]))
        else $error("bridge select did not follow write");

    pwm_default_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rate_code == 3'h5) ##1 (rate_code == 3'h5) |->
            (pwm_rate_multiple == ($past(double_speed) ? 5'h08 : 5'h10)))
        else $error("switching multiple wrong for code 101");

    mono_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_stage |=> mono_source_select == $past(wr_data[1]))
        else $error("mono source did not follow write");

endmodule // channel_volume_mute_regs

`default_nettype wire

// >>> sim/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
    // Clock
    input  wire logic sys_clk,
    // Two-wire bus
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // ------------------------------------------------------------
    // Bus idles released, every phase 10 cycles, sda moves mid-low
    // ------------------------------------------------------------
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic bit_cycle(input logic d, output logic s);
        hw(5);
        sda_drv = d;
        hw(5);
        scl = 1'b1;
        hw(10);
        s = sda_line;
        scl = 1'b0;
    endtask

    task automatic start();
        hw(5);
        sda_drv = 1'b1;
        hw(5);
        scl = 1'b1;
        hw(10);
        sda_drv = 1'b0;
        hw(10);
        scl = 1'b0;
    endtask

    task automatic stop();
        hw(5);
        sda_drv = 1'b0;
        hw(5);
        scl = 1'b1;
        hw(10);
        sda_drv = 1'b1;
        hw(10);
    endtask

    // Ack is true when the device pulled the line low on the ninth clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = (s === 1'b0);
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, b[i]);
        bit_cycle(nack, s);
    endtask
endmodule // i2c_host_model

`default_nettype wire

// >>> sim/channel_volume_mute_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module channel_volume_mute_regs_test;
    typedef struct { logic [7:0] off; logic [7:0] w; logic [7:0] r; } row_s;
    logic       sys_clk, rst, addr_sel, double_speed, scl, sda_drv, sda_line;
    logic       sda_out, sda_oe_n, fade_enable, left_mute, right_mute;
    logic       parallel_bridge_select, mono_source_select;
    logic [8:0] left_gain_half_db, right_gain_half_db;
    logic [4:0] pwm_rate_multiple;
    logic [1:0] analog_gain_select;
    logic [7:0] dev, q;
    logic [7:0] sh [3:6];
    logic [4:0] rt [0:7] = '{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18};
    logic       a0, a1, a2;
    int         err_total = 0;
    int         n_tests = 0;
    row_s       rows [24] = '{
        '{8'h03, 8'h00, 8'h00}, '{8'h03, 8'h01, 8'h01}, '{8'h03, 8'h02, 8'h02},
        '{8'h03, 8'h83, 8'h83}, '{8'h03, 8'h80, 8'h80}, '{8'h04, 8'hFF, 8'hFF},
        '{8'h04, 8'hFE, 8'hFE}, '{8'h04, 8'h07, 8'h07}, '{8'h04, 8'h06, 8'h06},
        '{8'h04, 8'h00, 8'h00}, '{8'h04, 8'h9E, 8'h9E}, '{8'h05, 8'hFF, 8'hFF},
        '{8'h05, 8'h07, 8'h07}, '{8'h05, 8'h06, 8'h06}, '{8'h05, 8'h01, 8'h01},
        '{8'h05, 8'hCF, 8'hCF}, '{8'h06, 8'h01, 8'h01}, '{8'h06, 8'h13, 8'h13},
        '{8'h06, 8'h25, 8'h25}, '{8'h06, 8'h37, 8'h37}, '{8'h06, 8'hC9, 8'hC9},
        '{8'h06, 8'hD3, 8'hD3}, '{8'h06, 8'hE5, 8'hE5}, '{8'h06, 8'hF9, 8'hF9}};

    // ------------------------------------------------------------
    // Open-drain data line with pull-up, clock and design
    // ------------------------------------------------------------
    assign sda_line = sda_drv & (sda_oe_n | sda_out);

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    i2c_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    channel_volume_mute_regs uut (
        .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
        .double_speed(double_speed), .fade_enable(fade_enable),
        .left_mute(left_mute), .right_mute(right_mute),
        .left_gain_half_db(left_gain_half_db), .right_gain_half_db(right_gain_half_db),
        .parallel_bridge_select(parallel_bridge_select),
        .pwm_rate_multiple(pwm_rate_multiple), .analog_gain_select(analog_gain_select),
        .mono_source_select(mono_source_select));

    // ------------------------------------------------------------
    // Register access and output checks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        host.start();
        host.send_byte(dev, a0);
        host.send_byte(off, a1);
        host.send_byte(d, a2);
        host.stop();
        `CHK("write acks", 3'h7, {a0, a1, a2})
    endtask

    task automatic rd(input logic [7:0] off, output logic [7:0] d);
        host.start();
        host.send_byte(dev, a0);
        host.send_byte(off, a1);
        host.start();
        host.send_byte(dev | 8'h01, a2);
        host.recv_byte(1'b1, d);
        host.stop();
        `CHK("read acks", 3'h7, {a0, a1, a2})
    endtask

    task automatic check_all();
        `CHK("fade", sh[3][7], fade_enable)
        `CHK("left mute", sh[3][0] | (sh[4] < 8'h07), left_mute)
        `CHK("right mute", sh[3][1] | (sh[5] < 8'h07), right_mute)
        `CHK("left gain", {1'b0, sh[4]} - 9'h0CF, left_gain_half_db)
        `CHK("right gain", {1'b0, sh[5]} - 9'h0CF, right_gain_half_db)
        `CHK("bridge", sh[6][7], parallel_bridge_select)
        `CHK("rate", rt[sh[6][6:4]] >> double_speed, pwm_rate_multiple)
        `CHK("analog gain", sh[6][3:2], analog_gain_select)
        `CHK("mono source", sh[6][1], mono_source_select)
    endtask

    task automatic reset_check();
        sh[3] = 8'h80;
        sh[4] = 8'hCF;
        sh[5] = 8'hCF;
        sh[6] = 8'h51;
        check_all();
        for (int i = 3; i < 7; i++)
        begin
            rd(i[7:0], q);
            `CHK("reset value", sh[i], q)
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (95000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        addr_sel = 1'b0;
        double_speed = 1'b0;
        dev = 8'hA0;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        host.hw(10);
        reset_check();
        foreach (rows[i])
        begin
            wr(rows[i].off, rows[i].w);
            rd(rows[i].off, q);
            `CHK("readback", rows[i].r, q)
            sh[rows[i].off] = rows[i].r;
            check_all();
        end
        // Double speed halves the switching multiple
        double_speed = 1'b1;
        host.hw(4);
        check_all();
        double_speed = 1'b0;
        // Unmapped place takes no write and reads zero
        wr(8'h07, 8'hAA);
        rd(8'h07, q);
        `CHK("unmapped", 8'h00, q)
        // Foreign address is not acknowledged
        host.start();
        host.send_byte(8'hA4, a0);
        host.stop();
        `CHK("foreign ack", 1'b0, a0)
        // Strap moves the device address
        addr_sel = 1'b1;
        dev = 8'hA2;
        host.hw(10);
        wr(8'h04, 8'h55);
        sh[4] = 8'h55;
        rd(8'h04, q);
        `CHK("strap readback", 8'h55, q)
        check_all();
        addr_sel = 1'b0;
        dev = 8'hA0;
        // Reset in mid-run restores defaults
        rst = 1'b1;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        host.hw(10);
        reset_check();
        finish_test();
    end
endmodule // channel_volume_mute_regs_test

`default_nettype wire
